// ### rtl/emb_pkg.sv
// Shared types and constants of the ECC memory board controller
package emb_pkg;

   // Array geometry
   localparam int EMB_DW = 32;
   localparam int EMB_CW = 7;
   localparam int EMB_SW = 39;
   localparam int EMB_HAM = 6;
   localparam int EMB_POS_LAST = 38;
   localparam int EMB_AW = 17;
   localparam int EMB_BAW = 19;
   localparam int EMB_LANE_LO = 2;
   localparam int EMB_CNT_W = 5;
   localparam int EMB_NBYTES = 4;
   localparam int EMB_BYTE_W = 8;

   // Transfer size of a single access
   localparam logic [1:0] EMB_SZ_BYTE = 2'h0;
   localparam logic [1:0] EMB_SZ_HALF = 2'h1;
   localparam logic [1:0] EMB_SZ_WORD = 2'h2;

   // Block length code: words = 1 << code, at most 16; code 0 is a single transfer
   localparam logic [2:0] EMB_BLK_1 = 3'h0;
   localparam logic [2:0] EMB_BLK_16 = 3'h4;

   // Byte lane masks
   localparam logic [3:0] EMB_BE_ALL = 4'hf;
   localparam logic [3:0] EMB_BE_ONE = 4'h1;
   localparam logic [3:0] EMB_BE_LO_HALF = 4'h3;
   localparam logic [3:0] EMB_BE_HI_HALF = 4'hc;

   localparam logic [EMB_CNT_W-1:0] EMB_LEFT_ONE = 5'h01;
   localparam logic [EMB_AW-1:0] EMB_ADDR_STEP = 17'h00001;

   typedef enum logic [1:0] {
      EMB_RSP_NONE = 2'h0,
      EMB_RSP_ACK_INT = 2'h1,
      EMB_RSP_ACK_DONE = 2'h2,
      EMB_RSP_NAK = 2'h3
   } emb_rsp_e;

   typedef enum logic [6:0] {
      EMB_ST_IDLE = 7'h01,
      EMB_ST_RD_ISS = 7'h02,
      EMB_ST_RD_CHK = 7'h04,
      EMB_ST_RMW_ISS = 7'h08,
      EMB_ST_RMW_CHK = 7'h10,
      EMB_ST_WR = 7'h20,
      EMB_ST_BW_WAIT = 7'h40
   } emb_state_e;

   typedef struct packed {
      logic write;
      logic [1:0] size;
      logic [2:0] blk;
      logic [EMB_BAW-1:0] addr;
      logic [EMB_DW-1:0] wdata;
   } emb_req_s;

   typedef struct packed {
      emb_rsp_e code;
      logic [EMB_DW-1:0] data;
   } emb_rsp_s;

   typedef struct packed {
      logic [EMB_AW-1:0] addr;
      logic [EMB_SW-1:0] wdata;
      logic we;
      logic re;
   } emb_mem_s;

   typedef struct packed {
      logic dbl;
      logic [EMB_AW-1:0] addr;
   } emb_err_s;

   typedef struct packed {
      logic [EMB_DW-1:0] data;
      logic single;
      logic dbl;
   } emb_dec_s;

   typedef struct packed {
      emb_state_e st;
      logic [EMB_AW-1:0] addr;
      logic [EMB_CNT_W-1:0] left;
      logic [EMB_DW-1:0] wdata;
      logic [EMB_NBYTES-1:0] be;
      logic [EMB_SW-1:0] word;
      logic rsp_v;
      emb_rsp_s rsp;
      logic err_v;
      emb_err_s err;
   } emb_regs_s;

endpackage

// ### rtl/emb_ctrl.sv
// ECC memory board controller: bus slave, SEC-DED array access, posted writes
`timescale 1ns/10ps
// Functional notes
// - Each 32-bit word is stored with seven modified Hamming check bits as a 39-bit word.
// - The code corrects any single-bit error, detects any double-bit error and flags some wider ones.
// - Every read fetches the whole 32-bit word, and smaller objects are taken from it by the master.
// - An error-free read returns its data with a normal acknowledge.
// - A single-bit read error returns corrected data with a normal acknowledge and no write-back.
// - A double-bit read error returns an error response with undefined data.
// - Byte, half-word and word writes are posted: latched, acknowledged at once, written afterwards.
// - A full word write stores the data with freshly generated check bits.
// - A byte or half-word write first reads the word, merges the new bytes and writes it back.
// - A single-bit error in that read is corrected before the merge.
// - A double-bit error in that read cancels the write, reports it only on ERR and leaves the bad word in place.
// - Block reads of 2, 4, 8 or 16 consecutive words check and correct every word.
// - Block read words get an intermediate acknowledge, the last one the final acknowledge.
// - A double-bit error in a block read returns an error response and ends the block.
// - Block writes of 2, 4, 8 or 16 words latch each word with intermediate then final acknowledge.
// - Each block write word is written whole with new check bits and the address then steps by one.
module emb_ctrl
   import emb_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic REQ_VALID,
   input wire emb_req_s REQ,
   output logic REQ_READY,
   output logic RSP_VALID,
   output emb_rsp_s RSP,
   output emb_mem_s MEM,
   input wire logic [EMB_SW-1:0] MEM_RDATA,
   output logic ERR_VALID,
   output emb_err_s ERR
);

   localparam emb_regs_s EMB_RESET = '{st: EMB_ST_IDLE, rsp: '{code: EMB_RSP_NONE, data: '0}, default: '0};

   emb_regs_s q;
   emb_regs_s d;
   emb_dec_s dec;
   logic [EMB_DW-1:0] merged;
   logic [EMB_CNT_W-1:0] blk_words;

   // Check bit generator over a 38-position Hamming frame plus overall parity
   function automatic logic [EMB_CW-1:0] ecc_gen(input logic [EMB_DW-1:0] dat);
      logic [EMB_POS_LAST:0] cw;
      logic [EMB_HAM-1:0] c;
      int k;
      cw = '0;
      c = '0;
      k = 0;
      for (int p = 1; p <= EMB_POS_LAST; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw[p] = dat[k];
            k++;
         end
      end
      for (int i = 0; i < EMB_HAM; i++) begin
         for (int p = 1; p <= EMB_POS_LAST; p++) begin
            if (p[i] && ((p & (p - 1)) != 0)) begin
               c[i] = c[i] ^ cw[p];
            end
         end
      end
      return {^{dat, c}, c};
   endfunction

   // Syndrome decode; overall parity tells odd from even error counts
   function automatic emb_dec_s ecc_dec(input logic [EMB_SW-1:0] w);
      logic [EMB_POS_LAST:0] cw;
      logic [EMB_HAM-1:0] syn;
      logic perr;
      int k;
      emb_dec_s r;
      cw = '0;
      syn = '0;
      k = 0;
      r = '0;
      for (int p = 1; p <= EMB_POS_LAST; p++) begin
         if ((p & (p - 1)) != 0) begin
            cw[p] = w[k];
            k++;
         end
      end
      for (int i = 0; i < EMB_HAM; i++) begin
         cw[1 << i] = w[EMB_DW + i];
      end
      for (int i = 0; i < EMB_HAM; i++) begin
         for (int p = 1; p <= EMB_POS_LAST; p++) begin
            if (p[i]) begin
               syn[i] = syn[i] ^ cw[p];
            end
         end
      end
      perr = ^w;
      if (perr) begin
         if (syn == '0) begin
            r.single = 1'b1;
         end else if (int'(syn) <= EMB_POS_LAST) begin
            cw[syn] = ~cw[syn];
            r.single = 1'b1;
         end else begin
            // Syndrome off the frame: three or more bits wrong
            r.dbl = 1'b1;
         end
      end else if (syn != '0) begin
         r.dbl = 1'b1;
      end
      k = 0;
      for (int p = 1; p <= EMB_POS_LAST; p++) begin
         if ((p & (p - 1)) != 0) begin
            r.data[k] = cw[p];
            k++;
         end
      end
      return r;
   endfunction

   function automatic logic [EMB_NBYTES-1:0] lane_mask(input logic [1:0] size, input logic [1:0] lo);
      logic [EMB_NBYTES-1:0] m;
      case (size)
         EMB_SZ_BYTE: begin
            m = EMB_BE_ONE << lo;
         end
         EMB_SZ_HALF: begin
            m = lo[1] ? EMB_BE_HI_HALF : EMB_BE_LO_HALF;
         end
         default: begin
            m = EMB_BE_ALL;
         end
      endcase
      return m;
   endfunction

   // Whole word always read; narrow reads pick their lanes from it
   assign dec = ecc_dec(MEM_RDATA);

   always_comb begin
      for (int b = 0; b < EMB_NBYTES; b++) begin
         merged[b*EMB_BYTE_W +: EMB_BYTE_W] = q.be[b] ? q.wdata[b*EMB_BYTE_W +: EMB_BYTE_W]
                                                       : dec.data[b*EMB_BYTE_W +: EMB_BYTE_W];
      end
   end

   // Block length above sixteen words is clipped to sixteen
   assign blk_words = (REQ.blk > EMB_BLK_16) ? (EMB_LEFT_ONE << EMB_BLK_16) : (EMB_LEFT_ONE << REQ.blk);

   always_comb begin
      d = q;
      d.rsp_v = 1'b0;
      d.err_v = 1'b0;
      case (q.st)
         EMB_ST_IDLE: begin
            if (REQ_VALID) begin
               d.addr = REQ.addr[EMB_BAW-1:EMB_LANE_LO];
               d.left = blk_words;
               if (REQ.write) begin
                  // Posted: acknowledge now, array write follows
                  d.wdata = REQ.wdata;
                  d.be = (REQ.blk != EMB_BLK_1) ? EMB_BE_ALL : lane_mask(REQ.size, REQ.addr[1:0]);
                  d.rsp_v = 1'b1;
                  d.rsp.code = (blk_words != EMB_LEFT_ONE) ? EMB_RSP_ACK_INT : EMB_RSP_ACK_DONE;
                  d.rsp.data = '0;
                  if (d.be == EMB_BE_ALL) begin
                     d.word = {ecc_gen(REQ.wdata), REQ.wdata};
                     d.st = EMB_ST_WR;
                  end else begin
                     d.st = EMB_ST_RMW_ISS;
                  end
               end else begin
                  d.st = EMB_ST_RD_ISS;
               end
            end
         end
         EMB_ST_RD_ISS: begin
            d.st = EMB_ST_RD_CHK;
         end
         EMB_ST_RD_CHK: begin
            d.rsp_v = 1'b1;
            d.rsp.data = dec.data;
            d.err_v = dec.single | dec.dbl;
            d.err.dbl = dec.dbl;
            d.err.addr = q.addr;
            if (dec.dbl) begin
               d.rsp.code = EMB_RSP_NAK;
               d.st = EMB_ST_IDLE;
            end else if (q.left == EMB_LEFT_ONE) begin
               d.rsp.code = EMB_RSP_ACK_DONE;
               d.st = EMB_ST_IDLE;
            end else begin
               d.rsp.code = EMB_RSP_ACK_INT;
               d.addr = q.addr + EMB_ADDR_STEP;
               d.left = q.left - EMB_LEFT_ONE;
               d.st = EMB_ST_RD_ISS;
            end
         end
         EMB_ST_RMW_ISS: begin
            d.st = EMB_ST_RMW_CHK;
         end
         EMB_ST_RMW_CHK: begin
            d.err_v = dec.single | dec.dbl;
            d.err.dbl = dec.dbl;
            d.err.addr = q.addr;
            if (dec.dbl) begin
               // Leave the bad word so a later read reports it
               d.st = EMB_ST_IDLE;
            end else begin
               d.word = {ecc_gen(merged), merged};
               d.st = EMB_ST_WR;
            end
         end
         EMB_ST_WR: begin
            d.left = q.left - EMB_LEFT_ONE;
            if (q.left != EMB_LEFT_ONE) begin
               d.addr = q.addr + EMB_ADDR_STEP;
               d.st = EMB_ST_BW_WAIT;
            end else begin
               d.st = EMB_ST_IDLE;
            end
         end
         EMB_ST_BW_WAIT: begin
            if (REQ_VALID) begin
               d.wdata = REQ.wdata;
               d.word = {ecc_gen(REQ.wdata), REQ.wdata};
               d.rsp_v = 1'b1;
               d.rsp.code = (q.left == EMB_LEFT_ONE) ? EMB_RSP_ACK_DONE : EMB_RSP_ACK_INT;
               d.rsp.data = '0;
               d.st = EMB_ST_WR;
            end
         end
         default: begin
            d = EMB_RESET;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         q <= EMB_RESET;
      end else begin
         q <= d;
      end
   end

   // Single-word reads never write back, so a corrected word stays wrong in the array
   assign REQ_READY = (q.st == EMB_ST_IDLE) || (q.st == EMB_ST_BW_WAIT);
   assign RSP_VALID = q.rsp_v;
   assign RSP = q.rsp;
   // One driver for the whole array port struct
   assign MEM = '{
      addr: q.addr,
      wdata: q.word,
      we: (q.st == EMB_ST_WR),
      re: (q.st == EMB_ST_RD_ISS) || (q.st == EMB_ST_RMW_ISS)
   };
   assign ERR_VALID = q.err_v;
   assign ERR = q.err;

endmodule // emb_ctrl

// ### verif/emb_ctrl_props.sv
// Port timing checker of the ECC memory board controller
`timescale 1ns/10ps
module emb_ctrl_props
   import emb_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic REQ_VALID,
   input wire emb_req_s REQ,
   input wire logic REQ_READY,
   input wire logic RSP_VALID,
   input wire emb_rsp_s RSP,
   input wire emb_mem_s MEM,
   input wire logic [EMB_SW-1:0] MEM_RDATA,
   input wire logic ERR_VALID,
   input wire emb_err_s ERR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   wire tk = REQ_VALID && REQ_READY;
   wire one = tk && REQ.blk == EMB_BLK_1;
   wire nak = RSP_VALID && RSP.code == EMB_RSP_NAK;
   sequence s_ack;
      RSP_VALID && RSP.code == EMB_RSP_ACK_DONE;
   endsequence
   sequence s_fetch;
      MEM.re && MEM.addr == $past(REQ.addr[18:2]);
   endsequence
   chk_word_post: assert property (one && REQ.write && REQ.size == EMB_SZ_WORD
      |=> s_ack ##0 (MEM.we && MEM.addr == $past(REQ.addr[18:2]))) else $error("word write not posted");
   chk_part_rmw: assert property (one && REQ.write && REQ.size != EMB_SZ_WORD
      |=> s_ack ##0 s_fetch ##2 (MEM.we != (ERR_VALID && ERR.dbl))) else $error("partial write sequence wrong");
   chk_rd_fetch: assert property (tk && !REQ.write |=> s_fetch ##2 RSP_VALID)
      else $error("read timing wrong");
   chk_rd_nowb: assert property (one && !REQ.write |=> !MEM.we [*3])
      else $error("read wrote back");
   chk_nak_dbl: assert property (nak |-> ERR_VALID && ERR.dbl)
      else $error("error response without double");
   // Checked in the error cycle: a new request may be taken on the edge closing it
   chk_nak_end: assert property (nak |-> REQ_READY)
      else $error("block read not ended");
   chk_blk_step: assert property (RSP_VALID && RSP.code == EMB_RSP_ACK_INT && MEM.re
      |-> MEM.addr == $past(MEM.addr, 2) + EMB_ADDR_STEP) else $error("block read address step wrong");
   chk_rw_excl: assert property (MEM.re |-> !MEM.we ##1 !MEM.re)
      else $error("read strobe not single");
   chk_store_par: assert property (MEM.we |-> !(^MEM.wdata))
      else $error("stored word parity odd");
endmodule // emb_ctrl_props

bind emb_ctrl emb_ctrl_props u_props (.CLK(CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID), .REQ(REQ),
   .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP(RSP), .MEM(MEM), .MEM_RDATA(MEM_RDATA),
   .ERR_VALID(ERR_VALID), .ERR(ERR));

// ### verif/emb_mem_model.sv
// Behavioural word array behind the controller, with fault injection
`timescale 1ns/10ps
module emb_mem_model
   import emb_pkg::*;
(
   input wire logic clk,
   input wire emb_mem_s mem,
   input wire logic flip_en,
   input wire logic [5:0] flip_addr,
   input wire logic [EMB_SW-1:0] flip_mask,
   output logic [EMB_SW-1:0] rdata
);
   logic [EMB_SW-1:0] arr [64];
   initial rdata = '0;
   always @(posedge clk) begin
      if (mem.we)
         arr[mem.addr[5:0]] <= mem.wdata;
      if (flip_en)
         arr[flip_addr] <= arr[flip_addr] ^ flip_mask;
      // Inverse outside the read slot, so a late sample is caught
      rdata <= mem.re ? arr[mem.addr[5:0]] : ~rdata;
   end
endmodule // emb_mem_model

// ### verif/emb_ctrl_tb_top.sv
// Self-checking bench of the ECC memory board controller
`timescale 1ns/10ps
module emb_ctrl_tb_top
   import emb_pkg::*;
;
   logic clk, resetn, req_v, rdy, rsp_v, err_v, flip_en;
   emb_req_s req;
   emb_rsp_s rsp;
   emb_mem_s mem;
   emb_err_s err;
   logic [EMB_SW-1:0] rdata, flip_mask;
   logic [5:0] flip_addr;
   logic [EMB_DW-1:0] shadow [64];
   logic [33:0] rq[$], eq[$], e;
   int mismatches, check_count, seed, i, k;
   emb_ctrl DUT (.CLK(clk), .RESETN(resetn), .REQ_VALID(req_v), .REQ(req), .REQ_READY(rdy), .RSP_VALID(rsp_v),
      .RSP(rsp), .MEM(mem), .MEM_RDATA(rdata), .ERR_VALID(err_v), .ERR(err));
   emb_mem_model u_mem (.clk(clk), .mem(mem), .flip_en(flip_en), .flip_addr(flip_addr), .flip_mask(flip_mask),
      .rdata(rdata));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic send(input logic w, input logic [1:0] sz, input logic [2:0] b, input int a, input logic [31:0] wd);
      req <= '{w, sz, b, EMB_BAW'(a), wd};
      req_v <= 1'b1;
      do @(negedge clk); while (rdy !== 1'b1);
      @(posedge clk);
   endtask
   // Idle the bus, wait out the block, then inject bit faults
   task automatic flip(input int wa, input logic [EMB_SW-1:0] m);
      req_v <= 1'b0;
      do @(negedge clk); while (rdy !== 1'b1);
      @(posedge clk);
      flip_en <= 1'b1;
      flip_addr <= 6'(wa);
      flip_mask <= m;
      @(posedge clk);
      flip_en <= 1'b0;
   endtask
   task automatic wr(input int a, input logic [1:0] sz, input logic [31:0] m);
      logic [31:0] d;
      d = $random(seed);
      shadow[a>>2] = (shadow[a>>2] & ~m) | (d & m);
      rq.push_back({EMB_RSP_ACK_DONE, 32'h0});
      send(1'b1, sz, EMB_BLK_1, a, d);
   endtask
   task automatic rd(input int a, input emb_rsp_e c);
      rq.push_back({c, shadow[a>>2]});
      send(1'b0, EMB_SZ_WORD, EMB_BLK_1, a, 32'h0);
   endtask
   task automatic blk(input logic w, input int b, input int last);
      for (int j = 0; j < (1 << b) && j <= last; j++) begin
         if (w)
            shadow[j] = $random(seed);
         rq.push_back({j == last ? EMB_RSP_NAK : j == (1 << b) - 1 ? EMB_RSP_ACK_DONE : EMB_RSP_ACK_INT,
            w ? 32'h0 : shadow[j]});
         if (w || j == 0)
            send(w, EMB_SZ_WORD, 3'(b), 0, shadow[j]);
      end
      flip(0, '0);
   endtask
   always @(negedge clk) begin
      if (rsp_v === 1'b1) begin
         e = rq.size() ? rq.pop_front() : 34'h0;
         check({rsp.code, e[33:32] == EMB_RSP_NAK ? e[31:0] : rsp.data}, e);
      end
      if (err_v === 1'b1)
         check({16'h0, err}, eq.size() ? eq.pop_front() : 34'h0);
   end
   initial begin
      resetn = 1'b0;
      req_v = 1'b0;
      req = '0;
      flip_en = 1'b0;
      flip_addr = '0;
      flip_mask = '0;
      mismatches = 0;
      check_count = 0;
      seed = 32'h30ebb176;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      for (k = 1; k <= 4; k++) begin
         blk(1'b1, k, 99);
         blk(1'b0, k, 99);
      end
      flip(2, 39'h6);
      eq.push_back({16'h0, 1'b1, 17'd2});
      blk(1'b0, 2, 2);
      for (i = 0; i < EMB_SW; i++) begin
         wr(160, EMB_SZ_WORD, '1);
         flip(40, 39'h1 << i);
         eq.push_back({16'h0, 1'b0, 17'd40});
         eq.push_back({16'h0, 1'b0, 17'd40});
         rd(160, EMB_RSP_ACK_DONE);
         rd(160, EMB_RSP_ACK_DONE);
         // No write-back, so the first bad bit is still stored: add one other bit
         flip(40, 39'h1 << ((i + 1) % EMB_SW));
         eq.push_back({16'h0, 1'b1, 17'd40});
         rd(160, EMB_RSP_NAK);
      end
      for (i = 0; i < 4; i++) begin
         wr(164, EMB_SZ_WORD, '1);
         wr(164 + i, EMB_SZ_BYTE, 32'hff << (8 * i));
         rd(164, EMB_RSP_ACK_DONE);
      end
      flip(41, 39'h1 << 20);
      eq.push_back({16'h0, 1'b0, 17'd41});
      wr(166, EMB_SZ_HALF, 32'hffff0000);
      rd(164, EMB_RSP_ACK_DONE);
      flip(41, 39'h5 << 9);
      eq.push_back({16'h0, 1'b1, 17'd41});
      eq.push_back({16'h0, 1'b1, 17'd41});
      wr(165, EMB_SZ_BYTE, 32'h0);
      rd(164, EMB_RSP_NAK);
      flip(0, '0);
      repeat (4) @(posedge clk);
      check(34'(rq.size() + eq.size()), 34'h0);
      finish_test();
   end
   initial begin
      repeat (50000) @(posedge clk);
      mismatches++;
      finish_test();
   end
endmodule // emb_ctrl_tb_top
